// ---- logic/secondary_irq_flag_enable_regs.sv ----
//Contract
// - serial interface request flag is bit 7 of control register two.
// - control two holds group 4,3,2 flags at 6,5,4, enables 2,1,0.
// - serial interface enable is bit 3 of control two, 1 enables.
// - control three holds time base 1 flag bit 6, base 0 bit 5.
// - control three enables: time base 1 bit2, base 0 bit1, port bit0.
// - control three holds group 5 flag bit 7, enable bit 3.
// - std timer register holds compare A, P flags at bits 5, 4.
// - std timer register holds compare A, P enables at bits 1, 0.
// - periodic timer 0 register holds compare A, P flags bits 5, 4.
// - periodic timer 0 register holds compare A, P enables bits 1, 0.
// - periodic timer 1 register: flags bits 5, 4; enables bits 1, 0.
// - periodic timer 2 register holds compare A, P flags bits 5, 4.
// - periodic timer 2 register holds compare A, P enables bits 1, 0.
// - timer registers bits 7-6 and 3-2 are unimplemented, read zero.
// - a source event sets its request flag.
// - interrupt raised only when flag and enable are both one.
// - global enable at zero blocks every interrupt.
// - flags still record events while interrupts are blocked.
`timescale 1ns/1ps
module secondary_irq_flag_enable_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire irq_regs_pkg::irq_src_t event_i,
  output irq_regs_pkg::irq_src_t flag_o,
  output irq_regs_pkg::irq_src_t pending_o,
  output logic irq_o
);

  // -------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------
  // the map needs byte addresses up to the global enable word
  if (ADDR_W < 5 || ADDR_W > 8)
  begin : g_bad_addr_w
    $error("ADDR_W must lie between 5 and 8");
  end

  localparam int NS = irq_regs_pkg::NUM_SLOTS;
  localparam int SPR = irq_regs_pkg::SLOTS_PER_REG;
  localparam int NR = irq_regs_pkg::NUM_REGS;

  // -------------------------------------------------------------
  // bus phase decode
  // -------------------------------------------------------------
  logic apb_setup;
  logic apb_access;
  logic apb_write;
  logic lane0_wr;

  assign apb_setup = psel_i & ~penable_i;
  assign apb_access = psel_i & penable_i;
  assign apb_write = apb_access & pwrite_i;
  // only the low byte lane carries register data
  assign lane0_wr = apb_write & pstrb_i[0];

  // -------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------
  logic [NR-1:0] reg_hit;
  logic glb_hit;
  logic any_hit;

  genvar r;
  generate
    for (r = 0; r < NR; r++)
    begin : g_hit
      assign reg_hit[r] = paddr_i ==
        ADDR_W'(irq_regs_pkg::REG_OFS_LIST[8*r +: 8]);
    end
  endgenerate

  assign glb_hit = paddr_i == ADDR_W'(irq_regs_pkg::OFS_GLOBAL_EN);
  assign any_hit = (|reg_hit) | glb_hit;

  // -------------------------------------------------------------
  // source to slot mapping
  // -------------------------------------------------------------
  // slot = register * 4 + position; flag sits 4 bits above enable
  logic [NS-1:0] ev_slot;
  logic [NS-1:0] flag_slot;
  logic [NS-1:0] enable_slot;
  logic [NS-1:0] pend_slot;

  // control register two
  assign ev_slot[3] = event_i.serial_iface_module;
  assign ev_slot[2] = event_i.multi_func_grp4;
  assign ev_slot[1] = event_i.multi_func_grp3;
  assign ev_slot[0] = event_i.multi_func_grp2;
  // control register three
  assign ev_slot[7] = event_i.multi_func_grp5;
  assign ev_slot[6] = event_i.time_base1;
  assign ev_slot[5] = event_i.time_base0;
  assign ev_slot[4] = event_i.second_serial_port;
  // standard timer register
  assign ev_slot[11:10] = 2'b00;
  assign ev_slot[9] = event_i.std_timer_cmpa;
  assign ev_slot[8] = event_i.std_timer_cmpp;
  // periodic timer 0 register
  assign ev_slot[15:14] = 2'b00;
  assign ev_slot[13] = event_i.periodic_timer0_cmpa;
  assign ev_slot[12] = event_i.periodic_timer0_cmpp;
  // periodic timer 1 register
  assign ev_slot[19:18] = 2'b00;
  assign ev_slot[17] = event_i.periodic_timer1_cmpa;
  assign ev_slot[16] = event_i.periodic_timer1_cmpp;
  // periodic timer 2 register
  assign ev_slot[23:22] = 2'b00;
  assign ev_slot[21] = event_i.periodic_timer2_cmpa;
  assign ev_slot[20] = event_i.periodic_timer2_cmpp;

  // -------------------------------------------------------------
  // named register fields
  // -------------------------------------------------------------
  // one wire per register bit, so the read bytes below can be held
  // against the register map by eye instead of by slot arithmetic
  logic serial_iface_req_flag;
  logic multi_func_grp4_flag;
  logic multi_func_grp3_flag;
  logic multi_func_grp2_flag;
  logic serial_iface_irq_enable;
  logic multi_func_grp4_enable;
  logic multi_func_grp3_enable;
  logic multi_func_grp2_enable;
  logic multi_func_grp5_flag;
  logic time_base1_flag;
  logic time_base0_flag;
  logic second_serial_port_flag;
  logic multi_func_grp5_enable;
  logic time_base1_enable;
  logic time_base0_enable;
  logic second_serial_port_enable;
  logic std_timer_cmpa_flag;
  logic std_timer_cmpp_flag;
  logic std_timer_cmpa_enable;
  logic std_timer_cmpp_enable;
  logic periodic_timer0_cmpa_flag;
  logic periodic_timer0_cmpp_flag;
  logic periodic_timer0_cmpa_enable;
  logic periodic_timer0_cmpp_enable;
  logic periodic_timer1_cmpa_flag;
  logic periodic_timer1_cmpp_flag;
  logic periodic_timer1_cmpa_enable;
  logic periodic_timer1_cmpp_enable;
  logic periodic_timer2_cmpa_flag;
  logic periodic_timer2_cmpp_flag;
  logic periodic_timer2_cmpa_enable;
  logic periodic_timer2_cmpp_enable;

  // control register two
  assign serial_iface_req_flag = flag_slot[3];
  assign multi_func_grp4_flag = flag_slot[2];
  assign multi_func_grp3_flag = flag_slot[1];
  assign multi_func_grp2_flag = flag_slot[0];
  assign serial_iface_irq_enable = enable_slot[3];
  assign multi_func_grp4_enable = enable_slot[2];
  assign multi_func_grp3_enable = enable_slot[1];
  assign multi_func_grp2_enable = enable_slot[0];
  // control register three
  assign multi_func_grp5_flag = flag_slot[7];
  assign time_base1_flag = flag_slot[6];
  assign time_base0_flag = flag_slot[5];
  assign second_serial_port_flag = flag_slot[4];
  assign multi_func_grp5_enable = enable_slot[7];
  assign time_base1_enable = enable_slot[6];
  assign time_base0_enable = enable_slot[5];
  assign second_serial_port_enable = enable_slot[4];
  // standard timer register
  assign std_timer_cmpa_flag = flag_slot[9];
  assign std_timer_cmpp_flag = flag_slot[8];
  assign std_timer_cmpa_enable = enable_slot[9];
  assign std_timer_cmpp_enable = enable_slot[8];
  // periodic timer 0 register
  assign periodic_timer0_cmpa_flag = flag_slot[13];
  assign periodic_timer0_cmpp_flag = flag_slot[12];
  assign periodic_timer0_cmpa_enable = enable_slot[13];
  assign periodic_timer0_cmpp_enable = enable_slot[12];
  // periodic timer 1 register
  assign periodic_timer1_cmpa_flag = flag_slot[17];
  assign periodic_timer1_cmpp_flag = flag_slot[16];
  assign periodic_timer1_cmpa_enable = enable_slot[17];
  assign periodic_timer1_cmpp_enable = enable_slot[16];
  // periodic timer 2 register
  assign periodic_timer2_cmpa_flag = flag_slot[21];
  assign periodic_timer2_cmpp_flag = flag_slot[20];
  assign periodic_timer2_cmpa_enable = enable_slot[21];
  assign periodic_timer2_cmpp_enable = enable_slot[20];

  // -------------------------------------------------------------
  // global enable register
  // -------------------------------------------------------------
  logic global_en_r;
  logic global_en_nxt;

  assign global_en_nxt = (lane0_wr & glb_hit) ?
    pwdata_i[irq_regs_pkg::GLOBAL_EN_BIT] : global_en_r;

  // blocks all vectoring while low, flags keep recording
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      global_en_r <= irq_regs_pkg::RST_GLOBAL_EN;
    else
      global_en_r <= global_en_nxt;
  end

  // -------------------------------------------------------------
  // flag and enable slots
  // -------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < NS; s++)
    begin : g_slot
      logic slot_wr;
      logic wflag;
      logic wenable;

      // same byte layout in every register of the group
      assign slot_wr = lane0_wr & reg_hit[s / SPR];
      assign wflag = pwdata_i[irq_regs_pkg::FLAG_LSB + (s % SPR)];
      assign wenable = pwdata_i[irq_regs_pkg::ENABLE_LSB + (s % SPR)];

      irq_slot #(
        .IMPL(irq_regs_pkg::SLOT_IMPL[s])
      ) u_slot (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .event_i(ev_slot[s]),
        .wr_i(slot_wr),
        .wflag_i(wflag),
        .wenable_i(wenable),
        .global_en_i(global_en_r),
        .flag_o(flag_slot[s]),
        .enable_o(enable_slot[s]),
        .pending_o(pend_slot[s])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // read data
  // -------------------------------------------------------------
  logic [7:0] reg_byte [NR];
  logic [7:0] rd_byte;
  logic [7:0] glb_byte;

  // flags in the high nibble, enables in the low nibble
  assign reg_byte[0] = {serial_iface_req_flag, multi_func_grp4_flag,
    multi_func_grp3_flag, multi_func_grp2_flag, serial_iface_irq_enable,
    multi_func_grp4_enable, multi_func_grp3_enable,
    multi_func_grp2_enable};
  assign reg_byte[1] = {multi_func_grp5_flag, time_base1_flag,
    time_base0_flag, second_serial_port_flag, multi_func_grp5_enable,
    time_base1_enable, time_base0_enable,
    second_serial_port_enable};
  // timer registers: unused bits are constant zero, never stored
  assign reg_byte[2] = {2'b00, std_timer_cmpa_flag, std_timer_cmpp_flag,
    2'b00, std_timer_cmpa_enable, std_timer_cmpp_enable};
  assign reg_byte[3] = {2'b00, periodic_timer0_cmpa_flag,
    periodic_timer0_cmpp_flag, 2'b00, periodic_timer0_cmpa_enable,
    periodic_timer0_cmpp_enable};
  assign reg_byte[4] = {2'b00, periodic_timer1_cmpa_flag,
    periodic_timer1_cmpp_flag, 2'b00, periodic_timer1_cmpa_enable,
    periodic_timer1_cmpp_enable};
  assign reg_byte[5] = {2'b00, periodic_timer2_cmpa_flag,
    periodic_timer2_cmpp_flag, 2'b00, periodic_timer2_cmpa_enable,
    periodic_timer2_cmpp_enable};

  assign glb_byte = {7'h00, global_en_r};

  // one hot select, so an or of the masked bytes is enough
  always_comb
  begin
    rd_byte = glb_hit ? glb_byte : 8'h00;
    for (int i = 0; i < NR; i++)
      rd_byte = rd_byte | (reg_hit[i] ? reg_byte[i] : 8'h00);
  end

  // -------------------------------------------------------------
  // bus answer
  // -------------------------------------------------------------
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // snapshot taken at the end of setup, so no wait state is needed;
  // a flag that sets during the access cycle shows on the next read
  assign prdata_nxt = (apb_setup & ~pwrite_i) ?
    {24'h00_0000, rd_byte} : prdata_r;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      prdata_r <= irq_regs_pkg::RST_RDATA;
    else
      prdata_r <= prdata_nxt;
  end

  assign prdata_o = prdata_r;
  assign pready_o = 1'b1; // never stalls the master
  assign pslverr_o = apb_access & ~any_hit; // unmapped address

  // -------------------------------------------------------------
  // source outputs
  // -------------------------------------------------------------
  // control register two
  assign flag_o.serial_iface_module = flag_slot[3];
  assign flag_o.multi_func_grp4 = flag_slot[2];
  assign flag_o.multi_func_grp3 = flag_slot[1];
  assign flag_o.multi_func_grp2 = flag_slot[0];
  // control register three
  assign flag_o.multi_func_grp5 = flag_slot[7];
  assign flag_o.time_base1 = flag_slot[6];
  assign flag_o.time_base0 = flag_slot[5];
  assign flag_o.second_serial_port = flag_slot[4];
  // timer registers
  assign flag_o.std_timer_cmpa = flag_slot[9];
  assign flag_o.std_timer_cmpp = flag_slot[8];
  assign flag_o.periodic_timer0_cmpa = flag_slot[13];
  assign flag_o.periodic_timer0_cmpp = flag_slot[12];
  assign flag_o.periodic_timer1_cmpa = flag_slot[17];
  assign flag_o.periodic_timer1_cmpp = flag_slot[16];
  assign flag_o.periodic_timer2_cmpa = flag_slot[21];
  assign flag_o.periodic_timer2_cmpp = flag_slot[20];

  // gated requests toward the vectoring logic
  assign pending_o.serial_iface_module = pend_slot[3];
  assign pending_o.multi_func_grp4 = pend_slot[2];
  assign pending_o.multi_func_grp3 = pend_slot[1];
  assign pending_o.multi_func_grp2 = pend_slot[0];
  assign pending_o.multi_func_grp5 = pend_slot[7];
  assign pending_o.time_base1 = pend_slot[6];
  assign pending_o.time_base0 = pend_slot[5];
  assign pending_o.second_serial_port = pend_slot[4];
  assign pending_o.std_timer_cmpa = pend_slot[9];
  assign pending_o.std_timer_cmpp = pend_slot[8];
  assign pending_o.periodic_timer0_cmpa = pend_slot[13];
  assign pending_o.periodic_timer0_cmpp = pend_slot[12];
  assign pending_o.periodic_timer1_cmpa = pend_slot[17];
  assign pending_o.periodic_timer1_cmpp = pend_slot[16];
  assign pending_o.periodic_timer2_cmpa = pend_slot[21];
  assign pending_o.periodic_timer2_cmpp = pend_slot[20];

  // any gated request; each term is a flip-flop or, for unimplemented bits, a constant zero
  assign irq_o = |pend_slot;

endmodule

// ---- logic/irq_regs_pkg.sv ----
package irq_regs_pkg;

  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam int NUM_REGS = 6;
  localparam int SLOTS_PER_REG = 4;
  localparam int NUM_SLOTS = NUM_REGS * SLOTS_PER_REG;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h00;
  localparam logic [7:0] OFS_CTRL_THREE = 8'h04;
  localparam logic [7:0] OFS_MULTI_STD_TIMER = 8'h08;
  localparam logic [7:0] OFS_MULTI_PERIODIC0 = 8'h0C;
  localparam logic [7:0] OFS_MULTI_PERIODIC1 = 8'h10;
  localparam logic [7:0] OFS_MULTI_PERIODIC2 = 8'h14;
  localparam logic [7:0] OFS_GLOBAL_EN = 8'h18;

  // offsets packed, register 0 in the low byte
  localparam logic [8*NUM_REGS-1:0] REG_OFS_LIST = {
    OFS_MULTI_PERIODIC2, OFS_MULTI_PERIODIC1, OFS_MULTI_PERIODIC0,
    OFS_MULTI_STD_TIMER, OFS_CTRL_THREE, OFS_CTRL_TWO};

  // -------------------------------------------------------------
  // field layout
  // -------------------------------------------------------------
  localparam int FLAG_LSB = 4;
  localparam int ENABLE_LSB = 0;
  localparam int GLOBAL_EN_BIT = 0;
  localparam logic [3:0] MASK_PRIMARY = 4'hF;
  localparam logic [3:0] MASK_MULTI = 4'h3;
  localparam logic [NUM_SLOTS-1:0] SLOT_IMPL = {
    MASK_MULTI, MASK_MULTI, MASK_MULTI, MASK_MULTI,
    MASK_PRIMARY, MASK_PRIMARY};

  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_GLOBAL_EN = 1'b0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // one bit per interrupt source
  typedef struct packed {
    logic serial_iface_module;
    logic multi_func_grp5;
    logic multi_func_grp4;
    logic multi_func_grp3;
    logic multi_func_grp2;
    logic time_base1;
    logic time_base0;
    logic second_serial_port;
    logic std_timer_cmpa;
    logic std_timer_cmpp;
    logic periodic_timer0_cmpa;
    logic periodic_timer0_cmpp;
    logic periodic_timer1_cmpa;
    logic periodic_timer1_cmpp;
    logic periodic_timer2_cmpa;
    logic periodic_timer2_cmpp;
  } irq_src_t;

endpackage

// ---- logic/irq_slot.sv ----
`timescale 1ns/1ps
module irq_slot #(
  parameter bit IMPL = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic event_i,
  input wire logic wr_i,
  input wire logic wflag_i,
  input wire logic wenable_i,
  input wire logic global_en_i,
  output logic flag_o,
  output logic enable_o,
  output logic pending_o
);

  generate
    if (IMPL) begin : g_impl
      logic flag_r;
      logic flag_nxt;
      logic enable_r;
      logic enable_nxt;
      logic pending_r;
      logic pending_nxt;

      // -----------------------------------------------------------
      // next values
      // -----------------------------------------------------------
      // event beats a software clear in the same cycle
      assign flag_nxt = event_i | (wr_i ? wflag_i : flag_r);
      assign enable_nxt = wr_i ? wenable_i : enable_r;
      // gated by flag, enable and global enable
      assign pending_nxt = flag_r & enable_r & global_en_i;

      // state, cleared on reset
      always_ff @(posedge core_clk_i)
      begin
        if (rst_i)
        begin
          flag_r <= irq_regs_pkg::RST_FLAG;
          enable_r <= irq_regs_pkg::RST_ENABLE;
          pending_r <= 1'b0;
        end
        else
        begin
          flag_r <= flag_nxt;
          enable_r <= enable_nxt;
          pending_r <= pending_nxt;
        end
      end

      assign flag_o = flag_r;
      assign enable_o = enable_r;
      assign pending_o = pending_r;
    end
    else begin : g_empty
      // unimplemented bit: no storage, reads zero
      assign flag_o = 1'b0;
      assign enable_o = 1'b0;
      assign pending_o = 1'b0;
    end
  endgenerate

endmodule

// ---- bench/irq_regs_chk_asserts.sv ----
`timescale 1ns/1ps
module irq_regs_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire irq_regs_pkg::irq_src_t event_i,
  input wire irq_regs_pkg::irq_src_t flag_o,
  input wire irq_regs_pkg::irq_src_t pending_o,
  input wire logic irq_o
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic glob_r;
  wire logic [15:0] fl = flag_o;
  wire logic [15:0] pd = pending_o;
  wire logic [15:0] ev = event_i;
  wire logic [3:0] c2f = {fl[15], fl[13:11]};
  wire logic acc = psel_i && penable_i;
  wire logic rd = acc && !pwrite_i;
  wire logic [7:0] a = 8'(paddr_i);
  wire logic mapped = a <= 8'h18 && a[1:0] == 2'b00;
  // shadow of global enable, since the design hides it
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      glob_r <= 1'b0;
    else if (acc && pwrite_i && pstrb_i[0] && a == 8'h18)
      glob_r <= pwdata_i[0];
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_flag_set;
    |ev |=> (fl & $past(ev)) == $past(ev);
  endproperty
  property p_flag_hold;
    !(acc && pwrite_i) |=> (fl & $past(fl)) == $past(fl);
  endproperty
  property p_pend_sub;
    (pd & ~$past(fl)) == 16'h0000;
  endproperty
  property p_glob_off;
    !glob_r |=> pd == 16'h0000;
  endproperty
  property p_irq_or;
    irq_o == |pd;
  endproperty
  property p_err;
    acc |-> pslverr_o == !mapped && pready_o;
  endproperty
  property p_unimpl;
    rd && a >= 8'h08 && a <= 8'h14 |-> (prdata_o & 32'hFFFF_FFCC) == 0;
  endproperty
  property p_ctrl2;
    rd && a == 8'h00 |-> prdata_o[7:4] == $past(c2f);
  endproperty
  // reset must clear state, so this one is not disabled by it
  property p_reset;
    disable iff (1'b0)
    rst_i |=> fl == 16'h0000 && pd == 16'h0000 && !irq_o;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("event did not set flag");
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without write");
  a_pend_sub: assert property (p_pend_sub)
    else $error("pending without flag");
  a_glob_off: assert property (p_glob_off)
    else $error("pending with global off");
  a_irq_or: assert property (p_irq_or)
    else $error("irq not OR of pending");
  a_err: assert property (p_err)
    else $error("bad slave error or ready");
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bit read one");
  a_ctrl2: assert property (p_ctrl2)
    else $error("control two flags misplaced");
  a_reset: assert property (p_reset)
    else $error("reset left state set");
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (pslverr_o);
  c_blocked: cover property (!glob_r && |ev);
endmodule

bind secondary_irq_flag_enable_regs irq_regs_chk #(.ADDR_W(ADDR_W)) chk_i (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .event_i(event_i),
  .flag_o(flag_o), .pending_o(pending_o), .irq_o(irq_o));

// ---- bench/secondary_irq_flag_enable_regs_tb_top.sv ----
`timescale 1ns/1ps
module secondary_irq_flag_enable_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err;
  logic [15:0] ev = 16'h0000;
  logic [15:0] flag, pend;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  secondary_irq_flag_enable_regs secondary_irq_flag_enable_regs_i (
    .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .event_i(ev), .flag_o(flag), .pending_o(pend), .irq_o(irq));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one APB transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rd, e, "read");
  endtask

  // event seen at one edge, flag one later, pending one after that
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 16'h0000;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // register offset and flag bit of each source
  function automatic logic [7:0] ofs(input int i);
    if (i > 7)
      return (i inside {15, 13, 12, 11}) ? 8'h00 : 8'h04;
    return 8'h08 + 8'(4 * (3 - i / 2));
  endfunction
  function automatic int fb(input int i);
    case (i)
      15, 14: return 7;
      13, 10: return 6;
      12, 9, 7, 5, 3, 1: return 5;
      default: return 4;
    endcase
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({flag, pend}, 32'h0000_0000, "state after reset");
    for (int a = 0; a <= 24; a += 4)
      rdc(8'(a), 32'h0000_0000);
  endtask

  task automatic t_rw();
    logic [31:0] e;
    for (int a = 0; a <= 20; a += 4)
    begin
      e = (a < 8) ? 32'h0000_00FF : 32'h0000_0033;
      apb(1'b1, 8'(a), 32'hFFFF_FFFF, 4'hF);
      rdc(8'(a), e);
      apb(1'b1, 8'(a), 32'h0000_0000, 4'hE);
      rdc(8'(a), e);
      apb(1'b1, 8'(a), 32'h0000_0000, 4'hF);
      rdc(8'(a), 32'h0000_0000);
    end
  endtask

  // each source alone: flag place, enable place, pending and irq
  task automatic t_src();
    apb(1'b1, 8'h18, 32'h0000_0001, 4'hF);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, ofs(i), 32'(1) << (fb(i) - 4), 4'hF);
      pulse(i);
      chk({16'h0, flag}, 32'(1) << i, "flag");
      chk({16'h0, pend}, 32'(1) << i, "pending");
      chk({31'h0, irq}, 32'h1, "irq");
      rdc(ofs(i), 32'h11 << (fb(i) - 4));
      // clear this source's flag and enable, then nothing may pend
      apb(1'b1, ofs(i), 32'h0000_0000, 4'hF);
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0, pend, irq}, 32'h0, "cleared");
    end
  endtask

  task automatic t_block();
    apb(1'b1, 8'h18, 32'h0000_0000, 4'hF);
    apb(1'b1, 8'h04, 32'h0000_000F, 4'hF);
    pulse(9);
    chk({16'h0, flag}, 32'h0000_0200, "blocked flag");
    chk({15'h0, pend, irq}, 32'h0, "blocked");
    apb(1'b1, 8'h18, 32'h0000_0001, 4'hF);
    @(posedge clk);
    #1;
    chk({16'h0, pend}, 32'h0000_0200, "released");
    // flag kept but its enable dropped: nothing pending
    apb(1'b1, 8'h04, 32'h0000_0020, 4'hF);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, pend, irq}, 32'h0, "disabled");
    apb(1'b1, 8'h04, 32'h0000_0000, 4'hF);
  endtask

  task automatic t_err();
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF, 4'hF);
    chk({31'h0, err}, 32'h1, "write err");
    rdc(8'h1C, 32'h0000_0000);
    chk({31'h0, err}, 32'h1, "read err");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      $display("mismatch at %0t: run timed out", $time);
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_src();
    t_block();
    t_err();
    tally_and_finish();
  end
endmodule
